// ==== mtl_locator.sv ====
// Locator words and per-entry lower message address storage.
// The locator words are elaboration constants with no register behind them.
// Assumes upstream decoders give single-cycle read/write strobes on sys_clk,
// and a message engine that requests one entry's address at a time.
//
// How it works
// - Table offset read-only in locator bits 31..3
// - Three-bit selector; 0..5 pick base registers
// - Bridge functions never report selector 2..5
// - Pending array offset read-only, bits 31..3
// - Pending selector encoded like table selector
// - Entry address drives address bits 31..2
// - Address bits 1..0 reset and stay zero
`timescale 1ns/10ps
`include "mtl_regs.svh"

module mtl_locator
    import mtl_pkg::*;
#(
    parameter int        NUM_ENTRIES   = 4,
    parameter bit        IS_BRIDGE     = 1'b0,
    parameter mtl_ofs_t  TABLE_OFFSET  = 29'h0,
    parameter mtl_sel_t  TABLE_SEL     = 3'h0,
    parameter mtl_ofs_t  PEND_OFFSET   = 29'h200,
    parameter mtl_sel_t  PEND_SEL      = 3'h0,
    localparam int       IDX_W         = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Capability config access
    input  wire logic              cfgRead,
    input  wire logic              cfgWrite,
    input  wire logic [7:0]        cfgAddr,
    input  wire logic [31:0]       cfgWdata,
    output logic [31:0]            cfgRdata,
    output logic                   cfgRvalid,
    // Table memory access, one strobe per word
    input  wire logic              tblRead,
    input  wire logic              tblWrite,
    input  wire logic [IDX_W-1:0]  tblEntry,
    input  wire logic [1:0]        tblWord,
    input  wire logic [31:0]       tblWdata,
    output logic [31:0]            tblRdata,
    output logic                   tblRvalid,
    // Message engine request for an entry's address
    input  wire logic              msgReq,
    input  wire logic [IDX_W-1:0]  msgEntry,
    output logic [31:2]            msgAddr,
    output logic                   msgAddrValid
);

    // Bridges only have two base registers; anything past that is clamped to 0
    function automatic mtl_sel_t legalSel(input mtl_sel_t sel);
        mtl_sel_t lim;
        lim = IS_BRIDGE ? `MTL_SEL_BRIDGE_MAX : `MTL_SEL_MAX_LEGAL;
        return (sel > lim) ? 3'h0 : sel;
    endfunction

    // Only word 0 of an in-range entry is backed by storage
    function automatic bit entryHit(input logic [1:0] word, input logic [IDX_W-1:0] entry);
        return (word == `MTL_ENTRY_WORD_ADDR) && (int'(entry) < NUM_ENTRIES);
    endfunction

    // Reset image of an entry's lower address; only bits 31..2 are kept
    localparam logic [31:0] ADDR_RESET_WORD = `MTL_ADDR_RESET;

    // Locator words are elaboration constants; cfgWrite is never looked at
    wire logic [31:0] vecLoc  = {TABLE_OFFSET, legalSel(TABLE_SEL)};
    wire logic [31:0] pendLoc = {PEND_OFFSET, legalSel(PEND_SEL)};

    // Only bits 31..2 are stored; bits 1..0 are hard-wired zero
    mtl_addr_t entryAddr [NUM_ENTRIES];
    mtl_addr_t next_entryAddr [NUM_ENTRIES];

    // Next values, one group per registered process
    logic [31:0] next_cfgRdata;
    logic        next_cfgRvalid;
    logic [31:0] next_tblRdata;
    logic        next_tblRvalid;
    logic [31:2] next_msgAddr;
    logic        next_msgAddrValid;
    mtl_state_e  state;
    mtl_state_e  next_state;

    // Unmapped capability offsets read zero; writes never reach a register
    always_comb
    begin
        next_cfgRvalid = cfgRead;
        next_cfgRdata  = 32'h0;
        if (cfgRead)
        begin
            unique case (cfgAddr)
                `MTL_VEC_LOC_OFS:  next_cfgRdata = vecLoc;
                `MTL_PEND_LOC_OFS: next_cfgRdata = pendLoc;
                default:           next_cfgRdata = 32'h0;
            endcase
        end
    end

    // Entry storage: only word 0 of an in-range entry is written
    always_comb
    begin
        for (int i = 0; i < NUM_ENTRIES; i++)
        begin
            next_entryAddr[i] = entryAddr[i];
        end
        if (tblWrite && entryHit(tblWord, tblEntry))
        begin
            // Low two bits dropped; a nonzero write there cannot corrupt alignment
            next_entryAddr[tblEntry] = tblWdata[`MTL_ADDR_MSB:`MTL_ADDR_LSB];
        end
    end

    // Table read answer one cycle behind the strobe; bits 1..0 always read zero
    // A write and a read of one entry in one cycle: the read sees the old value
    always_comb
    begin
        next_tblRvalid = tblRead;
        next_tblRdata  = 32'h0;
        if (tblRead && entryHit(tblWord, tblEntry))
        begin
            next_tblRdata = {entryAddr[tblEntry], 2'b00};
        end
    end

    // Address latched on acceptance, valid one cycle later; a request while
    // sending is dropped, so the engine must space requests two cycles apart
    always_comb
    begin
        next_state        = state;
        next_msgAddr      = msgAddr;
        next_msgAddrValid = 1'b0;
        unique case (state)
            MTL_IDLE:
            begin
                if (msgReq && int'(msgEntry) < NUM_ENTRIES)
                begin
                    next_msgAddr = entryAddr[msgEntry];
                    next_state   = MTL_SEND;
                end
            end
            MTL_SEND:
            begin
                next_msgAddrValid = 1'b1;
                next_state        = MTL_IDLE;
            end
            default:
            begin
                // A corrupted one-hot code falls back to idle
                next_state = MTL_IDLE;
            end
        endcase
    end

    // Config answer: one-cycle pulse, data zero whenever no read was taken
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgRdata  <= 32'h0;
            cfgRvalid <= 1'b0;
        end
        else
        begin
            cfgRdata  <= next_cfgRdata;
            cfgRvalid <= next_cfgRvalid;
        end
    end

    // Every entry clears on reset; software must fill one before it is used
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_ENTRIES; i++)
            begin
                entryAddr[i] <= ADDR_RESET_WORD[`MTL_ADDR_MSB:`MTL_ADDR_LSB];
            end
        end
        else
        begin
            entryAddr <= next_entryAddr;
        end
    end

    // Table answer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tblRdata  <= 32'h0;
            tblRvalid <= 1'b0;
        end
        else
        begin
            tblRdata  <= next_tblRdata;
            tblRvalid <= next_tblRvalid;
        end
    end

    // Message path: held address, valid pulse and the two-state sequencer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msgAddr      <= 30'h0;
            msgAddrValid <= 1'b0;
            state        <= MTL_IDLE;
        end
        else
        begin
            msgAddr      <= next_msgAddr;
            msgAddrValid <= next_msgAddrValid;
            state        <= next_state;
        end
    end

endmodule // mtl_locator

// ==== mtl_locator_asserts.sv ====
// Checker for locator words, entry readback and message timing.
// Assumes a bind to mtl_locator with the same parameters.
`timescale 1ns/10ps
module mtl_locator_asserts
    import mtl_pkg::*;
#(
    parameter bit       IS_BRIDGE    = 1'b0,
    parameter mtl_ofs_t TABLE_OFFSET = 29'h0,
    parameter mtl_sel_t TABLE_SEL    = 3'h0,
    parameter mtl_ofs_t PEND_OFFSET  = 29'h0,
    parameter mtl_sel_t PEND_SEL     = 3'h0
)
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        cfgRead,
    input wire logic        cfgWrite,
    input wire logic        cfgRvalid,
    input wire logic        tblRvalid,
    input wire logic        msgReq,
    input wire logic        msgAddrValid,
    input wire logic [7:0]  cfgAddr,
    input wire logic [31:0] cfgRdata,
    input wire logic [31:0] tblRdata,
    input wire logic [31:2] msgAddr
);
    localparam mtl_sel_t SMAX = IS_BRIDGE ? 3'h1 : 3'h5;
    localparam mtl_sel_t TS = (TABLE_SEL > SMAX) ? 3'h0 : TABLE_SEL;
    localparam mtl_sel_t PS = (PEND_SEL > SMAX) ? 3'h0 : PEND_SEL;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_msg; !msgAddrValid ##1 msgAddrValid; endsequence
    property p_tofs; cfgRead && cfgAddr == 8'h04 |=> cfgRdata[31:3] == TABLE_OFFSET; endproperty
    a_tofs: assert property (p_tofs) else $error("table offset");
    property p_tsel; cfgRead && cfgAddr == 8'h04 |=> cfgRvalid && cfgRdata[2:0] == TS; endproperty
    a_tsel: assert property (p_tsel) else $error("table select");
    property p_brg; cfgRvalid |-> !IS_BRIDGE || cfgRdata[2:0] < 3'h2; endproperty
    a_brg: assert property (p_brg) else $error("bridge select");
    property p_pofs; cfgRead && cfgAddr == 8'h08 |=> cfgRdata[31:3] == PEND_OFFSET; endproperty
    a_pofs: assert property (p_pofs) else $error("pending offset");
    property p_psel; cfgRead && cfgAddr == 8'h08 |=> cfgRvalid && cfgRdata[2:0] == PS; endproperty
    a_psel: assert property (p_psel) else $error("pending select");
    property p_msg; $rose(msgReq) |=> s_msg; endproperty
    a_msg: assert property (p_msg) else $error("message timing");
    property p_hold; msgAddrValid |-> $stable(msgAddr); endproperty
    a_hold: assert property (p_hold) else $error("message address moved");
    property p_low; tblRvalid |-> tblRdata[1:0] == 2'h0; endproperty
    a_low: assert property (p_low) else $error("low bits");
    property p_ro; cfgWrite && !cfgRead |=> !cfgRvalid; endproperty
    a_ro: assert property (p_ro) else $error("write answered");
endmodule // mtl_locator_asserts

// ==== mtl_locator_tb.sv ====
// Self-checking bench for mtl_locator, built as a bridge and as a plain function.
// Assumes the checker and software model files are compiled first.
`timescale 1ns/10ps
module mtl_locator_tb;
    logic sys_clk = 0, rst_n = 0, cfgRead = 0, cfgWrite = 0, tblRead = 0, tblWrite = 0, msgReq = 0;
    logic [7:0]  cfgAddr = 0, barCfgOfs;
    logic [31:0] cfgWdata = 0, tblWdata = 0, cfgRdata, tblRdata, locWord = 0, rawAddr = 0, d;
    logic [31:0] offset, wrAddr;
    logic [31:0] cfgRdata2, loc2;
    logic [1:0]  tblEntry = 0, tblWord = 0, msgEntry = 0;
    logic [31:2] msgAddr;
    logic        cfgRvalid, tblRvalid, msgAddrValid;
    int          errors = 0, n_compared = 0;
    // Raw address beside the address expected back
    logic [63:0] rows [4] = '{64'hfee0_0003_fee0_0000, 64'h1234_5674_1234_5674,
                              64'hffff_fffe_ffff_fffc, 64'h0000_0001_0000_0000};
    // Bridge with a bridge-reserved table select, which must read back as 0
    mtl_locator #(.IS_BRIDGE(1'b1), .TABLE_OFFSET(29'h100), .TABLE_SEL(3'h4),
        .PEND_OFFSET(29'h180), .PEND_SEL(3'h1)) uut (.*);
    mtl_sw_model sw (.locWord(locWord), .rawAddr(rawAddr), .offset(offset),
        .barCfgOfs(barCfgOfs), .wrAddr(wrAddr));
    // Plain function with an in-range table select and a reserved pending select
    mtl_locator #(.IS_BRIDGE(1'b0), .TABLE_OFFSET(29'h40), .TABLE_SEL(3'h5),
        .PEND_OFFSET(29'h80), .PEND_SEL(3'h7)) uut2 (.sys_clk(sys_clk), .rst_n(rst_n),
        .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata2), .cfgRvalid(), .tblRead(tblRead), .tblWrite(tblWrite),
        .tblEntry(tblEntry), .tblWord(tblWord), .tblWdata(tblWdata), .tblRdata(),
        .tblRvalid(), .msgReq(msgReq), .msgEntry(msgEntry), .msgAddr(), .msgAddrValid());
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input bit wr, input logic [7:0] a);
        @(posedge sys_clk);
        {cfgWrite, cfgRead, cfgAddr, cfgWdata} <= {wr, !wr, a, 32'hffff_ffff};
        @(posedge sys_clk);
        {cfgWrite, cfgRead} <= 2'h0;
        @(negedge sys_clk);
        locWord = cfgRdata;
        loc2    = cfgRdata2;
        chk({31'h0, cfgRvalid}, {31'h0, !wr});
        #1;
    endtask
    task automatic tbl(input bit wr, input logic [1:0] e, input logic [31:0] v);
        @(posedge sys_clk);
        {tblWrite, tblRead, tblEntry, tblWdata} <= {wr, !wr, e, v};
        @(posedge sys_clk);
        {tblWrite, tblRead} <= 2'h0;
        @(negedge sys_clk);
        d = tblRdata;
        chk({31'h0, tblRvalid}, {31'h0, !wr});
    endtask
    task automatic msg(input logic [1:0] e);
        @(posedge sys_clk);
        {msgReq, msgEntry} <= {1'b1, e};
        @(posedge sys_clk);
        msgReq <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, msgAddrValid}, 32'h1);
    endtask
    task automatic end_sim;
        $display("errors %0d n_compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        tbl(1'b0, 2'h2, 32'h0);
        chk(d, 32'h0);
        foreach (rows[i])
        begin
            rawAddr = rows[i][63:32];
            #1;
            tbl(1'b1, 2'(i), wrAddr);
            tbl(1'b0, 2'(i), 32'h0);
            chk(d, rows[i][31:0]);
            msg(2'(i));
            chk({msgAddr, 2'h0}, rows[i][31:0]);
        end
        tbl(1'b1, 2'h3, 32'hfee0_0003);
        tbl(1'b0, 2'h3, 32'h0);
        chk(d, 32'hfee0_0000);
        // Words other than the lower address are not stored and read zero
        @(posedge sys_clk);
        tblWord <= 2'h1;
        tbl(1'b1, 2'h0, 32'h1111_1110);
        tbl(1'b0, 2'h0, 32'h0);
        chk(d, 32'h0);
        @(posedge sys_clk);
        tblWord <= 2'h0;
        tbl(1'b0, 2'h0, 32'h0);
        chk(d, 32'hfee0_0000);
        cfg(1'b1, 8'h04);
        cfg(1'b0, 8'h04);
        chk(locWord, 32'h0000_0800);
        chk(offset, 32'h0000_0800);
        chk(loc2, 32'h0000_0205);
        cfg(1'b0, 8'h08);
        chk(locWord, 32'h0000_0c01);
        chk(offset, 32'h0000_0c00);
        chk({24'h0, barCfgOfs}, 32'h14);
        chk(loc2, 32'h0000_0400);
        cfg(1'b0, 8'h0c);
        chk(locWord, 32'h0);
        msg(2'h0);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(negedge sys_clk);
        chk({msgAddr, 2'h0}, 32'h0);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        tbl(1'b0, 2'h1, 32'h0);
        chk(d, 32'h0);
        end_sim();
    end
    initial
    begin
        #50us;
        errors++;
        end_sim();
    end
endmodule // mtl_locator_tb
bind mtl_locator mtl_locator_asserts #(.IS_BRIDGE(IS_BRIDGE), .TABLE_OFFSET(TABLE_OFFSET),
    .TABLE_SEL(TABLE_SEL), .PEND_OFFSET(PEND_OFFSET), .PEND_SEL(PEND_SEL)) chk_i (.*);

// ==== mtl_pkg.sv ====
// Types shared by the vector-table locator block.
// Assumes the matching _regs.svh header supplies the numeric constants.
package mtl_pkg;

    typedef logic [2:0]  mtl_sel_t;
    typedef logic [28:0] mtl_ofs_t;
    typedef logic [29:0] mtl_addr_t;

    typedef enum logic [1:0]
    {
        MTL_IDLE = 2'b01,
        MTL_SEND = 2'b10
    } mtl_state_e;

endpackage

// ==== mtl_regs.svh ====
// Offsets, field positions, reset values and sizes for the vector-table locator block.
// Assumes a config-space decoder delivers byte offsets and a table-space decoder delivers word offsets.
`ifndef MTL_REGS_SVH
`define MTL_REGS_SVH

// Config-space byte offsets of the two locator words inside the capability
`define MTL_VEC_LOC_OFS      8'h04
`define MTL_PEND_LOC_OFS     8'h08

// Locator field layout
`define MTL_OFFSET_MSB       31
`define MTL_OFFSET_LSB       3
`define MTL_SEL_MSB          2
`define MTL_SEL_LSB          0

// Selector encodings
`define MTL_SEL_MAX_LEGAL    3'h5
`define MTL_SEL_BRIDGE_MAX   3'h1

// Entry layout: sixteen bytes per entry, lower address at word 0
`define MTL_ENTRY_WORD_ADDR  2'h0
`define MTL_ADDR_MSB         31
`define MTL_ADDR_LSB         2
`define MTL_ADDR_RESET       32'h0000_0000

// Config offset of the first base address register; each further one is 4 bytes on
`define MTL_BAR0_CFG_OFS     8'h10

`endif

// ==== mtl_sw_model.sv ====
// Configuration software view: forms offsets and clean entry addresses.
// Assumes the bench feeds it locator words and raw addresses.
`timescale 1ns/10ps
module mtl_sw_model
(
    input  wire logic [31:0] locWord,
    input  wire logic [31:0] rawAddr,
    output logic      [31:0] offset,
    output logic      [7:0]  barCfgOfs,
    output logic      [31:0] wrAddr
);
    assign offset = {locWord[31:3], 3'h0};
    assign barCfgOfs = 8'h10 + {3'h0, locWord[2:0], 2'h0};
    assign wrAddr = {rawAddr[31:2], 2'h0};
endmodule // mtl_sw_model
